// ===== logic/bcs_pkg.sv
package bcs_pkg;

  // ----------------------------------------------------------------
  // Instruction classes handled by the sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BCS_PUSH_IDX,
    BCS_RET,
    BCS_RET_CC,
    BCS_IRET,
    BCS_IRET_COMPAT,
    BCS_ROT_A,
    BCS_ROT_REG,
    BCS_ROT_HL,
    BCS_ROT_IDX,
    BCS_RLD
  } bcs_instr_e;

  // ----------------------------------------------------------------
  // Machine cycle kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BCS_MC_FETCH1,
    BCS_MC_FETCH2,
    BCS_MC_OPERAND,
    BCS_MC_IDLE,
    BCS_MC_MEMRD,
    BCS_MC_MEMWR,
    BCS_MC_STKRD,
    BCS_MC_STKRD_HALT
  } bcs_mc_e;

  // Address source reported with each cycle.
  typedef enum logic [2:0] {
    BCS_AD_PC,
    BCS_AD_SP,
    BCS_AD_SP1,
    BCS_AD_SPM1,
    BCS_AD_SPM2,
    BCS_AD_HL,
    BCS_AD_IDX,
    BCS_AD_NONE
  } bcs_addr_e;

  // Bus strobes, all active low.
  typedef struct packed {
    logic readStrobe_b;
    logic writeStrobe_b;
    logic memoryRequestStrobe_b;
    logic ioRequestStrobe_b;
    logic opcodeFetchStrobe_b;
    logic haltStrobe_b;
    logic firstFetchStatus;
  } bcs_strobe_s;

  // One step of an instruction's sequence.
  typedef struct packed {
    bcs_mc_e   kind;
    bcs_addr_e addr;
    logic      dataDrive;
  } bcs_step_s;

  localparam int          BCS_MAX_STEPS = 10;
  localparam logic [3:0]  BCS_STEP_ZERO = 4'h0;
  localparam bcs_strobe_s BCS_STROBE_IDLE = 7'h7F;

endpackage

// ===== logic/bcs_strobe_gen.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Strobe decoder for one machine cycle
// ----------------------------------------------------------------
module bcs_strobe_gen (
  // Cycle description
  input  wire bcs_pkg::bcs_mc_e    kind,
  input  wire logic                refetch,
  input  wire logic                compatFetch,
  input  wire logic                ioCompatControl,
  // Decoded strobes
  output bcs_pkg::bcs_strobe_s     strobe
);
  import bcs_pkg::*;

  // Idle is the default; each cycle kind pulls its own strobes low.
  always_comb begin
    strobe = BCS_STROBE_IDLE;
    case (kind)
      BCS_MC_FETCH1: begin
        strobe.readStrobe_b          = 1'b0;
        strobe.memoryRequestStrobe_b = 1'b0;
        strobe.firstFetchStatus      = refetch;
        strobe.opcodeFetchStrobe_b   = compatFetch ? ~ioCompatControl : 1'b0;
      end
      BCS_MC_FETCH2: begin
        strobe.readStrobe_b          = 1'b0;
        strobe.memoryRequestStrobe_b = 1'b0;
        strobe.opcodeFetchStrobe_b   = compatFetch ? ~ioCompatControl : 1'b0;
      end
      BCS_MC_OPERAND, BCS_MC_MEMRD, BCS_MC_STKRD: begin
        strobe.readStrobe_b          = 1'b0;
        strobe.memoryRequestStrobe_b = 1'b0;
      end
      BCS_MC_STKRD_HALT: begin
        strobe.readStrobe_b          = 1'b0;
        strobe.memoryRequestStrobe_b = 1'b0;
        strobe.haltStrobe_b          = 1'b0;
      end
      BCS_MC_MEMWR: begin
        strobe.writeStrobe_b         = 1'b0;
        strobe.memoryRequestStrobe_b = 1'b0;
      end
      BCS_MC_IDLE: begin
        strobe = BCS_STROBE_IDLE;
      end
      default: begin
        strobe = BCS_STROBE_IDLE;
      end
    endcase
    if (kind != BCS_MC_FETCH1) begin
      strobe.firstFetchStatus = 1'b1;
    end
  end

endmodule

// ===== logic/bcs_sequencer.sv
`timescale 1ns/1ps
// How it works
// - A failed conditional return does one opcode fetch then two idle states, no stack read.
// - An indexed rotate opens with a fetch with status low, then a second fetch with status high.
// - Its third cycle reads the displacement with read low and the fetch strobe high.
// - Its fourth cycle fetches the third opcode byte with the fetch strobe low.
// - Its fifth cycle reads memory at index plus displacement with read and request low.
// - One idle state follows, then a write to the same address with write and request low.
// - A rotate on the HL byte does two fetches, a read, one idle state and a write.
// - A rotate on a register does two fetches and one idle state with no data access.
// - The compatibility interrupt return runs fetch, fetch, three idles, refetch, idle,
//   refetch, two stack reads, with the first fetch strobes low only when compat control is 1.
module bcs_sequencer (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  // Instruction request
  input  wire logic                 start,
  input  wire bcs_pkg::bcs_instr_e  instr,
  input  wire logic                 conditionTrue,
  input  wire logic                 ioCompatControl,
  // Bus side
  output bcs_pkg::bcs_strobe_s      busStrobe,
  output bcs_pkg::bcs_addr_e        busAddrSel,
  output logic                      dataOutEnable,
  output logic                      busy,
  output logic                      done
);
  import bcs_pkg::*;

  // ----------------------------------------------------------------
  // Sequence table
  // ----------------------------------------------------------------
  // Steps are looked up combinationally so the table is the single
  // place describing each instruction's order of cycles.
  function automatic bcs_step_s stepOf(input bcs_instr_e ins, input logic cond,
                                       input logic [3:0] idx);
    bcs_step_s s;
    s = '{BCS_MC_IDLE, BCS_AD_NONE, 1'b0};
    case (ins)
      BCS_PUSH_IDX: begin
        case (idx)
          4'h0: s = '{BCS_MC_FETCH1, BCS_AD_PC, 1'b0};
          4'h1: s = '{BCS_MC_FETCH2, BCS_AD_PC, 1'b0};
          4'h4: s = '{BCS_MC_MEMWR, BCS_AD_SPM1, 1'b1};
          4'h5: s = '{BCS_MC_MEMWR, BCS_AD_SPM2, 1'b1};
          default: s = '{BCS_MC_IDLE, BCS_AD_NONE, 1'b0};
        endcase
      end
      BCS_RET: begin
        case (idx)
          4'h0: s = '{BCS_MC_FETCH1, BCS_AD_PC, 1'b0};
          4'h1: s = '{BCS_MC_STKRD, BCS_AD_SP, 1'b0};
          default: s = '{BCS_MC_STKRD, BCS_AD_SP1, 1'b0};
        endcase
      end
      BCS_RET_CC: begin
        if (idx == 4'h0) begin
          s = '{BCS_MC_FETCH1, BCS_AD_PC, 1'b0};
        end else if (!cond) begin
          s = '{BCS_MC_IDLE, BCS_AD_NONE, 1'b0};
        end else if (idx == 4'h2) begin
          s = '{BCS_MC_STKRD, BCS_AD_SP, 1'b0};
        end else if (idx == 4'h3) begin
          s = '{BCS_MC_STKRD, BCS_AD_SP1, 1'b0};
        end
      end
      BCS_IRET: begin
        case (idx)
          4'h0: s = '{BCS_MC_FETCH1, BCS_AD_PC, 1'b0};
          4'h1: s = '{BCS_MC_FETCH2, BCS_AD_PC, 1'b0};
          4'h2: s = '{BCS_MC_STKRD_HALT, BCS_AD_SP, 1'b0};
          default: s = '{BCS_MC_STKRD, BCS_AD_SP1, 1'b0};
        endcase
      end
      BCS_IRET_COMPAT: begin
        case (idx)
          4'h0: s = '{BCS_MC_FETCH1, BCS_AD_PC, 1'b0};
          4'h1: s = '{BCS_MC_FETCH2, BCS_AD_PC, 1'b0};
          4'h5: s = '{BCS_MC_FETCH1, BCS_AD_PC, 1'b0};
          4'h7: s = '{BCS_MC_FETCH2, BCS_AD_PC, 1'b0};
          4'h8: s = '{BCS_MC_STKRD, BCS_AD_SP, 1'b0};
          4'h9: s = '{BCS_MC_STKRD, BCS_AD_SP1, 1'b0};
          default: s = '{BCS_MC_IDLE, BCS_AD_NONE, 1'b0};
        endcase
      end
      BCS_ROT_A: begin
        s = '{BCS_MC_FETCH1, BCS_AD_PC, 1'b0};
      end
      BCS_ROT_REG: begin
        case (idx)
          4'h0: s = '{BCS_MC_FETCH1, BCS_AD_PC, 1'b0};
          4'h1: s = '{BCS_MC_FETCH2, BCS_AD_PC, 1'b0};
          default: s = '{BCS_MC_IDLE, BCS_AD_NONE, 1'b0};
        endcase
      end
      BCS_ROT_HL, BCS_RLD: begin
        case (idx)
          4'h0: s = '{BCS_MC_FETCH1, BCS_AD_PC, 1'b0};
          4'h1: s = '{BCS_MC_FETCH2, BCS_AD_PC, 1'b0};
          4'h2: s = '{BCS_MC_MEMRD, BCS_AD_HL, 1'b0};
          default: s = '{BCS_MC_IDLE, BCS_AD_NONE, 1'b0};
        endcase
        if (idx == lastOf(ins, cond)) begin
          s = '{BCS_MC_MEMWR, BCS_AD_HL, 1'b1};
        end
      end
      BCS_ROT_IDX: begin
        case (idx)
          4'h0: s = '{BCS_MC_FETCH1, BCS_AD_PC, 1'b0};
          4'h1: s = '{BCS_MC_FETCH2, BCS_AD_PC, 1'b0};
          4'h2: s = '{BCS_MC_OPERAND, BCS_AD_PC, 1'b0};
          4'h3: s = '{BCS_MC_FETCH2, BCS_AD_PC, 1'b0};
          4'h4: s = '{BCS_MC_MEMRD, BCS_AD_IDX, 1'b0};
          4'h5: s = '{BCS_MC_IDLE, BCS_AD_NONE, 1'b0};
          default: s = '{BCS_MC_MEMWR, BCS_AD_IDX, 1'b1};
        endcase
      end
      default: s = '{BCS_MC_IDLE, BCS_AD_NONE, 1'b0};
    endcase
    return s;
  endfunction

  // Index of the final machine cycle of each instruction.
  function automatic logic [3:0] lastOf(input bcs_instr_e ins, input logic cond);
    case (ins)
      BCS_PUSH_IDX:    lastOf = 4'h5;
      BCS_RET:         lastOf = 4'h2;
      BCS_RET_CC:      lastOf = cond ? 4'h3 : 4'h2;
      BCS_IRET:        lastOf = 4'h3;
      BCS_IRET_COMPAT: lastOf = 4'h9;
      BCS_ROT_A:       lastOf = 4'h0;
      BCS_ROT_REG:     lastOf = 4'h2;
      BCS_ROT_HL:      lastOf = 4'h4;
      BCS_ROT_IDX:     lastOf = 4'h6;
      BCS_RLD:         lastOf = 4'h7;
      default:         lastOf = 4'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Sequence state
  // ----------------------------------------------------------------
  typedef enum logic {BCS_SQ_IDLE, BCS_SQ_RUN} bcs_state_e;

  bcs_state_e  state;
  bcs_instr_e  curInstr;
  logic        curCond;
  logic [3:0]  stepIdx;
  bcs_instr_e  selInstr;
  logic        selCond;
  logic [3:0]  selIdx;
  bcs_step_s   curStep;
  bcs_strobe_s next_strobe;
  logic        launch;
  logic        isLast;

  // A new instruction is taken when idle or right after the last cycle,
  // so sequences may run back to back without a gap.
  assign launch   = start && (state == BCS_SQ_IDLE || isLast);
  assign isLast   = (state == BCS_SQ_RUN) && (stepIdx == lastOf(curInstr, curCond));
  assign selInstr = launch ? instr : curInstr;
  assign selCond  = launch ? conditionTrue : curCond;
  assign selIdx   = launch ? BCS_STEP_ZERO : stepIdx + 4'h1;
  assign curStep  = stepOf(selInstr, selCond, selIdx);

  bcs_strobe_gen strobeGen (
    .kind            (curStep.kind),
    .refetch         (selInstr == BCS_IRET_COMPAT && selIdx != BCS_STEP_ZERO),
    .compatFetch     (selInstr == BCS_IRET_COMPAT && selIdx < 4'h2),
    .ioCompatControl (ioCompatControl),
    .strobe          (next_strobe)
  );

  // Sequencer state and step counter.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state    <= BCS_SQ_IDLE;
      stepIdx  <= BCS_STEP_ZERO;
      curInstr <= BCS_ROT_A;
      curCond  <= 1'b0;
    end else if (launch) begin
      state    <= BCS_SQ_RUN;
      stepIdx  <= BCS_STEP_ZERO;
      curInstr <= instr;
      curCond  <= conditionTrue;
    end else if (isLast) begin
      state <= BCS_SQ_IDLE;
    end else if (state == BCS_SQ_RUN) begin
      stepIdx <= stepIdx + 4'h1;
    end
  end

  // Registered bus outputs; outside a sequence the bus rests idle.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      busStrobe     <= BCS_STROBE_IDLE;
      busAddrSel    <= BCS_AD_NONE;
      dataOutEnable <= 1'b0;
      busy          <= 1'b0;
    end else if (launch || (state == BCS_SQ_RUN && !isLast)) begin
      busStrobe     <= next_strobe;
      busAddrSel    <= curStep.addr;
      dataOutEnable <= curStep.dataDrive;
      busy          <= 1'b1;
    end else begin
      busStrobe     <= BCS_STROBE_IDLE;
      busAddrSel    <= BCS_AD_NONE;
      dataOutEnable <= 1'b0;
      busy          <= 1'b0;
    end
  end

  // Done pulses in the cycle the final machine cycle is shown.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      done <= 1'b0;
    end else begin
      done <= (launch && lastOf(instr, conditionTrue) == BCS_STEP_ZERO)
              || (state == BCS_SQ_RUN && !isLast && selIdx == lastOf(curInstr, curCond));
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  idle_floats_a: assert property (@(posedge mclk) disable iff (!rst_b)
    busStrobe.readStrobe_b && busStrobe.writeStrobe_b |-> !dataOutEnable)
    else $error("Data bus driven during an idle state.");

  retcc_fail_a: assert property (@(posedge mclk) disable iff (!rst_b)
    launch && instr == BCS_RET_CC && !conditionTrue
    |=> !busStrobe.opcodeFetchStrobe_b ##1 busStrobe == BCS_STROBE_IDLE [*2])
    else $error("Failed conditional return did not idle twice.");

  idx_fetch_a: assert property (@(posedge mclk) disable iff (!rst_b)
    launch && instr == BCS_ROT_IDX
    |=> !busStrobe.firstFetchStatus ##1
        (!busStrobe.opcodeFetchStrobe_b && busStrobe.firstFetchStatus))
    else $error("Indexed rotate fetch pair wrong.");

  idx_disp_a: assert property (@(posedge mclk) disable iff (!rst_b)
    launch && instr == BCS_ROT_IDX
    |=> ##2 (!busStrobe.readStrobe_b && busStrobe.opcodeFetchStrobe_b))
    else $error("Displacement read strobes wrong.");

  idx_third_a: assert property (@(posedge mclk) disable iff (!rst_b)
    launch && instr == BCS_ROT_IDX |=> ##3 !busStrobe.opcodeFetchStrobe_b)
    else $error("Third opcode fetch lacks fetch strobe.");

  idx_read_a: assert property (@(posedge mclk) disable iff (!rst_b)
    launch && instr == BCS_ROT_IDX
    |=> ##4 (!busStrobe.readStrobe_b && busAddrSel == BCS_AD_IDX))
    else $error("Indexed operand read missing.");

  idx_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
    launch && instr == BCS_ROT_IDX
    |=> ##5 busStrobe == BCS_STROBE_IDLE ##1
        (!busStrobe.writeStrobe_b && busStrobe.readStrobe_b && busAddrSel == BCS_AD_IDX))
    else $error("Indexed write-back sequence wrong.");

  hl_seq_a: assert property (@(posedge mclk) disable iff (!rst_b)
    launch && instr == BCS_ROT_HL
    |=> ##2 !busStrobe.readStrobe_b ##1 busStrobe == BCS_STROBE_IDLE ##1
        (!busStrobe.writeStrobe_b && busAddrSel == BCS_AD_HL))
    else $error("HL rotate sequence wrong.");

  reg_rot_a: assert property (@(posedge mclk) disable iff (!rst_b)
    launch && instr == BCS_ROT_REG |=> ##2 (busStrobe == BCS_STROBE_IDLE && done))
    else $error("Register rotate idle state wrong.");

  compat_a: assert property (@(posedge mclk) disable iff (!rst_b)
    launch && instr == BCS_IRET_COMPAT && !ioCompatControl
    |=> busStrobe.opcodeFetchStrobe_b ##5 !busStrobe.opcodeFetchStrobe_b
        ##3 (!busStrobe.readStrobe_b && busAddrSel == BCS_AD_SP))
    else $error("Compatibility return sequence wrong.");

endmodule

// ===== testbench/bcs_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Memory and I/O on the far side of the bus
// ----------------------------------------------------------------
module bcs_mem_model (
  // Bus from the sequencer
  input  wire logic                 mclk,
  input  wire bcs_pkg::bcs_strobe_s busStrobe,
  input  wire logic                 dataOutEnable,
  // Observations
  output logic [7:0]                memData,
  output logic [7:0]                readCount,
  output logic [7:0]                writeCount,
  output logic [7:0]                ioCount,
  output logic                      clash
);
  import bcs_pkg::*;
  logic       readOn;
  logic       writeOn;
  logic [7:0] pattern;

  // Decoded memory cycles; strobes are low when active.
  assign readOn  = !busStrobe.readStrobe_b && !busStrobe.memoryRequestStrobe_b;
  assign writeOn = !busStrobe.writeStrobe_b && !busStrobe.memoryRequestStrobe_b;
  // A released bus shows the inverse byte, so stale data never looks fresh.
  assign memData = readOn ? pattern : ~pattern;

  // Counters start from zero; the bench only uses differences.
  initial begin
    pattern    = 8'h5A;
    readCount  = 8'h00;
    writeCount = 8'h00;
    ioCount    = 8'h00;
    clash      = 1'b0;
  end

  // Every mclk is one machine cycle, so each edge counts one access.
  always @(posedge mclk) begin
    if (readOn) begin
      readCount <= readCount + 8'h01;
      pattern   <= pattern + 8'h11;
    end
    if (writeOn) begin
      writeCount <= writeCount + 8'h01;
    end
    if (!busStrobe.ioRequestStrobe_b) begin
      ioCount <= ioCount + 8'h01;
    end
    clash <= clash | (dataOutEnable & readOn);
  end
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import bcs_pkg::*;
  typedef struct {
    bcs_instr_e instr;
    logic       cond;
    logic       io_compat_control;
    string      kinds;
    string      addrs;
  } bcs_row_s;

  logic        mclk            = 1'b0;
  logic        rst_b           = 1'b0;
  logic        start           = 1'b0;
  bcs_instr_e  instr           = BCS_ROT_A;
  logic        conditionTrue   = 1'b0;
  logic        ioCompatControl = 1'b0;
  bcs_strobe_s busStrobe;
  bcs_addr_e   busAddrSel;
  logic        dataOutEnable;
  logic        busy;
  logic        done;
  logic [7:0]  memData;
  logic [7:0]  readCount;
  logic [7:0]  writeCount;
  logic [7:0]  ioCount;
  logic        clash;
  logic [7:0]  r0;
  logic [7:0]  w0;
  logic [7:0]  i0;
  int          failures = 0;
  int          checks   = 0;
  bcs_row_s    rows [12];

  // Clock at 50 ns period.
  always #25 mclk = ~mclk;

  bcs_sequencer uut (.mclk(mclk), .rst_b(rst_b), .start(start), .instr(instr),
    .conditionTrue(conditionTrue), .ioCompatControl(ioCompatControl),
    .busStrobe(busStrobe), .busAddrSel(busAddrSel), .dataOutEnable(dataOutEnable),
    .busy(busy), .done(done));

  bcs_mem_model mem (.mclk(mclk), .busStrobe(busStrobe), .dataOutEnable(dataOutEnable),
    .memData(memData), .readCount(readCount), .writeCount(writeCount),
    .ioCount(ioCount), .clash(clash));

  // ----------------------------------------------------------------
  // Verdict and comparisons
  // ----------------------------------------------------------------
  task automatic summarize();
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp_strobe(input bcs_strobe_s got, input bcs_strobe_s exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_addr(input bcs_addr_e got, input bcs_addr_e exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_count(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Letter codes for one machine cycle, strobe order rd wr memory_request_strobe io_request_strobe fetch halt status.
  function automatic bcs_strobe_s exp_strobe(input byte c);
    case (c)
      "F":     return 7'h2A;
      "S":     return 7'h2B;
      "R":     return 7'h2F;
      "H":     return 7'h2D;
      "W":     return 7'h4F;
      "e":     return 7'h2E;
      default: return 7'h7F;
    endcase
  endfunction

  function automatic bcs_addr_e exp_addr(input byte c);
    case (c)
      "P":     return BCS_AD_PC;
      "S":     return BCS_AD_SP;
      "T":     return BCS_AD_SP1;
      "U":     return BCS_AD_SPM1;
      "V":     return BCS_AD_SPM2;
      "H":     return BCS_AD_HL;
      "X":     return BCS_AD_IDX;
      default: return BCS_AD_NONE;
    endcase
  endfunction

  // Counts the cycles whose letter is one of those in set.
  function automatic logic [7:0] count_of(input string k, input string set);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < k.len(); i++) begin
      for (int j = 0; j < set.len(); j++) begin
        if (k[i] == set[j]) n = n + 8'h01;
      end
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Drivers and sequence checks
  // ----------------------------------------------------------------
  task automatic launch(input bcs_instr_e i, input logic c, input logic x);
    @(posedge mclk);
    instr           <= i;
    conditionTrue   <= c;
    ioCompatControl <= x;
    start           <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
  endtask

  // Checks one cycle per falling edge; an address of '-' is left open.
  task automatic check_seq(input string k, input string a, input logic [15:0] doneMask);
    for (int i = 0; i < k.len(); i++) begin
      @(negedge mclk);
      cmp_strobe(busStrobe, exp_strobe(k[i]));
      if (a[i] != "-") cmp_addr(busAddrSel, exp_addr(a[i]));
      cmp_bit(dataOutEnable, k[i] == "W");
      cmp_bit(busy, 1'b1);
      cmp_bit(done, doneMask[i]);
    end
  endtask

  task automatic check_idle(input logic withAddr);
    cmp_strobe(busStrobe, BCS_STROBE_IDLE);
    if (withAddr) cmp_addr(busAddrSel, BCS_AD_NONE);
    cmp_bit(dataOutEnable, 1'b0);
    cmp_bit(busy, 1'b0);
    cmp_bit(done, 1'b0);
  endtask

  // Watchdog sized well beyond the roughly 120 cycles the tests need.
  initial begin
    repeat (3000) @(posedge mclk);
    failures++;
    summarize();
  end

  initial begin
    rows = '{
      '{BCS_PUSH_IDX,    1'h0, 1'h0, "FSIIWW",     "PP--UV"},
      '{BCS_RET,         1'h0, 1'h0, "FRR",        "PST"},
      '{BCS_RET_CC,      1'h0, 1'h0, "FII",        "P--"},
      '{BCS_RET_CC,      1'h1, 1'h0, "FIRR",       "P-ST"},
      '{BCS_IRET,        1'h0, 1'h0, "FSHR",       "PPST"},
      '{BCS_IRET_COMPAT, 1'h0, 1'h1, "FSIIISISRR", "PP---P-PST"},
      '{BCS_IRET_COMPAT, 1'h0, 1'h0, "eRIIISISRR", "PP---P-PST"},
      '{BCS_ROT_A,       1'h0, 1'h0, "F",          "P"},
      '{BCS_ROT_REG,     1'h0, 1'h0, "FSI",        "PP-"},
      '{BCS_ROT_HL,      1'h0, 1'h0, "FSRIW",      "PPH-H"},
      '{BCS_ROT_IDX,     1'h0, 1'h0, "FSRSRIW",    "PPPPX-X"},
      '{BCS_RLD,         1'h0, 1'h0, "FSRIIIIW",   "PPH----H"}};
    // Reset held for 16 cycles, idle outputs during and just after it.
    repeat (15) @(posedge mclk);
    @(negedge mclk);
    check_idle(1'b1);
    @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    check_idle(1'b1);
    // Twelve rows over the ten instruction classes, memory traffic counted by the model.
    foreach (rows[n]) begin
      r0 = readCount;
      w0 = writeCount;
      i0 = ioCount;
      launch(rows[n].instr, rows[n].cond, rows[n].io_compat_control);
      check_seq(rows[n].kinds, rows[n].addrs, 16'h0001 << (rows[n].kinds.len() - 1));
      @(negedge mclk);
      check_idle(1'b0);
      cmp_count(8'(readCount - r0), count_of(rows[n].kinds, "FSRHe"));
      cmp_count(8'(writeCount - w0), count_of(rows[n].kinds, "W"));
      cmp_count(8'(ioCount - i0), 8'h00);
    end
    cmp_bit(clash, 1'b0);
    // Reset in mid-sequence: no write-back may follow.
    w0 = writeCount;
    launch(BCS_ROT_IDX, 1'h0, 1'h0);
    check_seq("FSR", "PPP", 16'h0000);
    @(posedge mclk);
    rst_b <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    check_idle(1'b1);
    @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    check_idle(1'b1);
    cmp_count(8'(writeCount - w0), 8'h00);
    // A start offered mid-run is ignored; one held into the last cycle chains.
    fork
      begin
        @(posedge mclk);
        instr <= BCS_ROT_REG;
        start <= 1'b1;
        @(posedge mclk);
        instr <= BCS_RET;
        @(posedge mclk);
        @(posedge mclk);
        instr <= BCS_ROT_A;
        @(posedge mclk);
        start <= 1'b0;
      end
      begin
        @(posedge mclk);
        @(posedge mclk);
        check_seq("FSIF", "PP-P", 16'h000C);
      end
    join
    @(negedge mclk);
    check_idle(1'b0);
    summarize();
  end
endmodule
